// *** scd_decoder.sv ***
// Notes on behaviour
// - Code 0000 is never a request; it marks error responses.
// - Odd codes ask data from source code[3:1]; 1000 writes, 1100 reads.
// - Read request: 1100, zeros, word address 23:17, byte select 16, CRC.
// - The seven address bits select a pair of adjacent byte registers.
// - Odd byte register goes in the high data byte, even in the low.
// - Read answer goes in the next frame when no framing, CRC or MISO error.
// - On any of these errors the read is answered with the error response.
// - Register contents are taken when select rises at frame end.
// - Address bits 23:17 are decoded as the word address of the pair.
// - Good read answer: echo 0110, status, 00, high, low, CRC.
// - Register error response: 0000, 11, 00, high byte, low byte, CRC.
`timescale 1ns/100ps
`default_nettype none
module scd_decoder
	import scd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe_n,
	input wire logic miso_fault,
	input wire logic cmd_crc_ok,
	input wire logic [7:0] resp_crc,
	input wire logic [7:0] reg_high_byte,
	input wire logic [7:0] reg_low_byte,
	input wire logic [11:0] sample_value,
	input wire logic sample_valid,
	input wire logic [1:0] detail_status,
	input wire logic [1:0] basic_status,
	output logic [31:0] cmd_frame,
	output logic [6:0] word_address,
	output logic [23:0] resp_payload,
	output logic frame_done,
	output logic write_req,
	output logic [7:0] write_address,
	output logic [7:0] write_data
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic {
		scd_st_idle,
		scd_st_shift
	} scd_state_e;

	typedef struct packed {
		scd_state_e state;
		logic cs_prev;
		logic sclk_prev;
		logic [31:0] rx;
		logic [31:0] tx;
		logic [5:0] count;
		logic [23:0] payload;
		logic [11:0] sample;
		logic sample_ok;
		logic [1:0] sf;
		logic [1:0] st;
		logic frame_done;
		logic write_req;
		logic [7:0] write_address;
		logic [7:0] write_data;
	} scd_dec_s;

	scd_dec_s s;
	scd_dec_s next_s;
	logic [2:0] pins_sync;
	logic sclk_s;
	logic cs_n_s;
	logic mosi_s;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	scd_sync u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in({spi_cs_n, spi_sclk, spi_mosi}),
		.sync_out(pins_sync)
	);

	// Split the synchronised pins back into their meanings.
	assign cs_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign mosi_s = pins_sync[0];

	// ----------------------------------------------------------------
	// Frame engine
	// ----------------------------------------------------------------
	// Shifts one frame in and out, then builds the next frame's answer.
	always_comb
	begin
		logic cs_fall;
		logic cs_rise;
		logic sclk_rise;
		logic sclk_fall;
		logic err;
		logic [3:0] code;
		logic [3:0] echo;
		logic [7:0] hi;
		logic [7:0] lo;
		scd_kind_e kind;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		err = 1'b0;
		code = 4'h0;
		echo = 4'h0;
		hi = 8'h00;
		lo = 8'h00;
		kind = scd_kind_reserved;
		next_s = s;
		next_s.frame_done = 1'b0;
		next_s.write_req = 1'b0;
		next_s.cs_prev = cs_n_s;
		next_s.sclk_prev = sclk_s;
		cs_fall = s.cs_prev & ~cs_n_s;
		cs_rise = ~s.cs_prev & cs_n_s;
		sclk_rise = ~s.sclk_prev & sclk_s;
		sclk_fall = s.sclk_prev & ~sclk_s;
		case (s.state)
			scd_st_idle:
			begin
				if (cs_fall)
				begin
					// The pending answer leaves MSB first in this frame.
					next_s.state = scd_st_shift;
					next_s.count = 6'h00;
					next_s.tx = {s.payload, resp_crc};
					next_s.sample = sample_value;
					next_s.sample_ok = sample_valid;
					next_s.sf = detail_status;
					next_s.st = basic_status;
				end
			end
			scd_st_shift:
			begin
				if (sclk_rise)
				begin
					next_s.rx = {s.rx[SCD_MSB-1:0], mosi_s};
					if (s.count != SCD_COUNT_MAX)
						next_s.count = s.count + 6'h01;
				end
				if (sclk_fall)
					next_s.tx = {s.tx[SCD_MSB-1:0], 1'b0};
				if (cs_rise)
				begin
					next_s.state = scd_st_idle;
					next_s.frame_done = 1'b1;
					code = s.rx[SCD_CMD_HI:SCD_CMD_LO];
					echo = scd_echo(code);
					kind = scd_classify(code);
					// Framing, CRC and MISO faults all spoil the request.
					err = (s.count != SCD_FRAME_BITS) | miso_fault |
						~cmd_crc_ok;
					// Contents are taken at the select's rising edge.
					hi = reg_high_byte;
					lo = reg_low_byte;
					case (kind)
						scd_kind_sensor:
						begin
							if (s.sample_ok)
								next_s.payload = scd_sensor_resp(echo,
									err ? SCD_STATUS_ERR : s.st,
									s.sample, s.sf);
							else
								next_s.payload = scd_nodata_resp(s.sf);
						end
						scd_kind_read:
						begin
							if (err)
								next_s.payload = scd_reg_resp(SCD_CODE_ERROR,
									SCD_STATUS_ERR, hi, lo);
							else
								next_s.payload = scd_reg_resp(echo, s.st,
									hi, lo);
						end
						scd_kind_write:
						begin
							if (err)
								next_s.payload = scd_reg_resp(SCD_CODE_ERROR,
									SCD_STATUS_ERR, hi, lo);
							else
							begin
								// Answer carries the pair as it stands after the write.
								next_s.write_req = 1'b1;
								next_s.write_address =
									s.rx[SCD_ADDR_HI:SCD_BSEL];
								next_s.write_data =
									s.rx[SCD_WDATA_HI:SCD_WDATA_LO];
								if (s.rx[SCD_BSEL])
									hi = s.rx[SCD_WDATA_HI:SCD_WDATA_LO];
								else
									lo = s.rx[SCD_WDATA_HI:SCD_WDATA_LO];
								next_s.payload = scd_reg_resp(echo, s.st,
									hi, lo);
							end
						end
						scd_kind_error_code:
							next_s.payload = scd_nodata_resp(s.sf);
						default:
							next_s.payload = scd_nodata_resp(s.sf);
					endcase
				end
			end
			default:
				next_s.state = scd_st_idle;
		endcase
	end

	// Registers the whole state; the first answer is the no-data error.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s.state <= scd_st_idle;
			s.cs_prev <= 1'b1;
			s.sclk_prev <= 1'b0;
			s.rx <= 32'h00000000;
			s.tx <= 32'h00000000;
			s.count <= 6'h00;
			s.payload <= SCD_RESET_PAYLOAD;
			s.sample <= 12'h000;
			s.sample_ok <= 1'b0;
			s.sf <= SCD_DETAIL_NONE;
			s.st <= 2'h0;
			s.frame_done <= 1'b0;
			s.write_req <= 1'b0;
			s.write_address <= 8'h00;
			s.write_data <= 8'h00;
		end
		else
			s <= next_s;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// MISO is driven only while a frame is in progress.
	assign spi_miso = s.tx[SCD_MSB];
	assign spi_miso_oe_n = (s.state != scd_st_shift);
	assign cmd_frame = s.rx;
	// The word address names the register pair that is read.
	assign word_address = s.rx[SCD_ADDR_HI:SCD_ADDR_LO];
	assign resp_payload = s.payload;
	assign frame_done = s.frame_done;
	assign write_req = s.write_req;
	assign write_address = s.write_address;
	assign write_data = s.write_data;

endmodule : scd_decoder
`default_nettype wire

// *** scd_pkg.sv ***
`default_nettype none
package scd_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] SCD_FRAME_BITS = 6'h20;
	localparam logic [5:0] SCD_COUNT_MAX = 6'h3f;
	localparam int SCD_CMD_HI = 31;
	localparam int SCD_CMD_LO = 28;
	localparam int SCD_ADDR_HI = 23;
	localparam int SCD_ADDR_LO = 17;
	localparam int SCD_BSEL = 16;
	localparam int SCD_WDATA_HI = 15;
	localparam int SCD_WDATA_LO = 8;
	localparam int SCD_MSB = 31;

	// ----------------------------------------------------------------
	// Command codes and status values
	// ----------------------------------------------------------------
	localparam logic [3:0] SCD_CODE_ERROR = 4'h0;
	localparam logic [3:0] SCD_CODE_WRITE = 4'h8;
	localparam logic [3:0] SCD_CODE_READ = 4'hc;
	localparam logic [1:0] SCD_STATUS_ERR = 2'h3;
	localparam logic [1:0] SCD_DETAIL_NONE = 2'h0;
	localparam logic [23:0] SCD_RESET_PAYLOAD = {4'h0, 2'h3, 16'h0000, 2'h0};

	typedef enum logic [2:0] {
		scd_kind_sensor,
		scd_kind_read,
		scd_kind_write,
		scd_kind_reserved,
		scd_kind_error_code
	} scd_kind_e;

	// ----------------------------------------------------------------
	// Decoding and response builders
	// ----------------------------------------------------------------
	// Classifies a command code; odd codes ask for sensor data.
	function automatic scd_kind_e scd_classify(input logic [3:0] code);
		scd_kind_e kind;
		kind = scd_kind_reserved;
		if (code[0])
			kind = scd_kind_sensor;
		else if (code == SCD_CODE_READ)
			kind = scd_kind_read;
		else if (code == SCD_CODE_WRITE)
			kind = scd_kind_write;
		else if (code == SCD_CODE_ERROR)
			kind = scd_kind_error_code;
		return kind;
	endfunction : scd_classify

	// Echo of the command field: low code bit first, then the upper three.
	function automatic logic [3:0] scd_echo(input logic [3:0] code);
		return {code[0], code[3:1]};
	endfunction : scd_echo

	// Register pair response body, bits 31:8 of the frame.
	function automatic logic [23:0] scd_reg_resp(input logic [3:0] cmd,
		input logic [1:0] st, input logic [7:0] hi, input logic [7:0] lo);
		return {cmd, st, 2'h0, hi, lo};
	endfunction : scd_reg_resp

	// Sensor data response body with the sample left justified.
	function automatic logic [23:0] scd_sensor_resp(input logic [3:0] cmd,
		input logic [1:0] st, input logic [11:0] sd, input logic [1:0] sf);
		return {cmd, st, sd, 4'h0, sf};
	endfunction : scd_sensor_resp

	// Error response body that carries no sample data.
	function automatic logic [23:0] scd_nodata_resp(input logic [1:0] sf);
		return {SCD_CODE_ERROR, SCD_STATUS_ERR, 16'h0000, sf};
	endfunction : scd_nodata_resp

endpackage : scd_pkg
`default_nettype wire

// *** scd_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module scd_sync
	import scd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [2:0] async_in,
	output logic [2:0] sync_out
);

	// ----------------------------------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} scd_sync_s;

	scd_sync_s s;
	scd_sync_s next_s;

	// The first stage feeds the second; only the second feeds the output.
	always_comb
	begin
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
	end

	// Idle levels: select high, clock and data low.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			s <= '{stage1: 3'h4, stage2: 3'h4};
		else
			s <= next_s;
	end

	assign sync_out = s.stage2;

endmodule : scd_sync
`default_nettype wire

// *** scd_decoder_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// Port checker for the command decoder.
// ----
module scd_decoder_properties (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_miso,
	input wire logic spi_miso_oe_n,
	input wire logic miso_fault,
	input wire logic cmd_crc_ok,
	input wire logic [7:0] reg_high_byte,
	input wire logic [7:0] reg_low_byte,
	input wire logic [31:0] cmd_frame,
	input wire logic [6:0] word_address,
	input wire logic [23:0] resp_payload,
	input wire logic frame_done,
	input wire logic write_req,
	input wire logic [7:0] write_address
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// Code of the frame just taken.
	logic [3:0] code;
	assign code = cmd_frame[31:28];

	// Error state, clock count and register pair, one cycle back.
	logic ok;
	logic good;
	logic sclk_q;
	logic cs_q;
	logic [5:0] n_rise;
	logic [15:0] pair;
	always_ff @(posedge ref_clk)
	begin
		ok <= cmd_crc_ok && !miso_fault;
		pair <= {reg_high_byte, reg_low_byte};
		sclk_q <= spi_sclk;
		cs_q <= spi_cs_n;
		if (cs_q && !spi_cs_n)
			n_rise <= 6'h00;
		else if (!spi_cs_n && spi_sclk && !sclk_q && n_rise != 6'h3f)
			n_rise <= n_rise + 6'h01;
	end

	// A request is good only with exactly 32 clocks and no fault.
	assign good = ok && (n_rise == 6'h20);

	miso_start_a: assert property ($fell(spi_cs_n) ##1
		!spi_cs_n[*6] |-> !spi_miso_oe_n && spi_miso == resp_payload[23])
		else $error("first response bit wrong");
	miso_idle_a: assert property (spi_cs_n[*6] |->
		spi_miso_oe_n) else $error("output enabled outside a frame");
	done_time_a: assert property ($rose(spi_cs_n) |->
		##[1:7] frame_done) else $error("frame end not reported");
	done_pulse_a: assert property (frame_done |->
		$past(spi_cs_n, 3) && !$past(spi_cs_n, 4) ##1 !frame_done)
		else $error("frame end pulse wrong");
	write_only_a: assert property (write_req |->
		frame_done && good && code == 4'h8)
		else $error("write issued wrongly");
	word_addr_a: assert property (frame_done |->
		word_address == cmd_frame[23:17] &&
		(!write_req || write_address == cmd_frame[23:16]))
		else $error("word address wrong");
	read_ok_a: assert property (frame_done && code == 4'hc && good |->
		resp_payload[23:20] == 4'h6 && resp_payload[17:0] == {2'h0, pair})
		else $error("read answer wrong");
	read_err_a: assert property (frame_done && code == 4'hc && !good |->
		resp_payload == {8'h0c, pair}) else $error("read error answer wrong");
	nodata_a: assert property (frame_done && !code[0] &&
		code != 4'h8 && code != 4'hc |-> resp_payload[23:2] == 22'h030000)
		else $error("no-data error answer wrong");
endmodule : scd_decoder_properties
`default_nettype wire

// *** scd_master.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// Behavioural SPI master, mode 0, 160 ns clock.
// ----
module scd_master (
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic miso_line
);
	// Idle bus: clock low, select high.
	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// Shifts one frame MSB first; data is sampled late in the high phase.
	// With extra set, one dummy clock leads the frame and spoils its count.
	task automatic xfer(input logic [31:0] tx, input logic extra,
		output logic [31:0] rx);
		spi_cs_n = 1'b0;
		#160;
		if (extra)
		begin
			#80 spi_sclk = 1'b1;
			#80 spi_sclk = 1'b0;
		end
		for (int i = 31; i >= 0; i--)
		begin
			spi_mosi = tx[i];
			#80 spi_sclk = 1'b1;
			#79 rx[i] = miso_line;
			#1 spi_sclk = 1'b0;
		end
		#80 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask : xfer
endmodule : scd_master
`default_nettype wire

// *** scd_decoder_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("MISMATCH %0t %s", $time, m); end end
// ----
// Bench for the command decoder.
// ----
module scd_decoder_tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
	logic miso_fault = 1'b0;
	logic cmd_crc_ok = 1'b1;
	logic [7:0] resp_crc = 8'h5a;
	logic [7:0] reg_high_byte = 8'h11;
	logic [7:0] reg_low_byte = 8'h22;
	logic [11:0] sample_value = 12'habc;
	logic sample_valid = 1'b1;
	logic [1:0] detail_status = 2'h2;
	logic [1:0] basic_status = 2'h1;
	wire [31:0] cmd_frame;
	wire [6:0] word_address;
	wire [23:0] resp_payload;
	wire frame_done, write_req;
	wire [7:0] write_address, write_data;
	wire miso_line = spi_miso_oe_n ? 1'bz : spi_miso;
	logic [23:0] prev = 24'h0c0000;
	logic [23:0] got_p;
	logic got_w;
	int n_done = 0;
	int total_checks = 0;
	int n_mismatch = 0;

	scd_decoder i_scd_decoder (.ref_clk, .nrst, .spi_sclk, .spi_cs_n,
		.spi_mosi, .spi_miso, .spi_miso_oe_n, .miso_fault, .cmd_crc_ok,
		.resp_crc, .reg_high_byte, .reg_low_byte, .sample_value,
		.sample_valid, .detail_status, .basic_status, .cmd_frame,
		.word_address, .resp_payload, .frame_done, .write_req,
		.write_address, .write_data);
	scd_master i_scd_master (.spi_sclk, .spi_cs_n, .spi_mosi, .miso_line);

	// Clock toggles every half period.
	always #10 ref_clk = ~ref_clk;

	// Captures the one-cycle outputs at each frame end.
	always @(posedge ref_clk)
		if (frame_done === 1'b1)
		begin
			n_done <= n_done + 1;
			got_p <= resp_payload;
			got_w <= write_req;
		end

	// Sends a request; checks its answer and the previous one on the wire.
	task automatic run(input logic [31:0] tx, input logic [23:0] e);
		logic [31:0] rx;
		int d;
		d = n_done;
		i_scd_master.xfer(tx, 1'b0, rx);
		`CHK(n_done, d + 1, "frame end")
		`CHK(got_p, e, "payload")
		`CHK(rx, {prev, resp_crc}, "wire frame")
		prev = e;
	endtask : run

	// Register pair is taken at select rise, not at select fall.
	task automatic t_read();
		fork
			run({8'hc0, 7'h55, 1'b1, 16'h0},
				{4'h6, basic_status, 18'h0a53c});
			#3000 {reg_high_byte, reg_low_byte} = 16'ha53c;
		join
		`CHK(word_address, 7'h55, "word address")
		`CHK(cmd_frame, {8'hc0, 7'h55, 1'b1, 16'h0}, "frame in")
	endtask : t_read

	// A MISO error, then a CRC error, turn a read into the error answer.
	task automatic t_read_err();
		for (int k = 0; k < 2; k++)
		begin
			{miso_fault, cmd_crc_ok} = k ? 2'b00 : 2'b11;
			run({8'hc0, 7'h2a, 1'b0, 16'h0}, 24'h0ca53c);
		end
		{miso_fault, cmd_crc_ok} = 2'b01;
	endtask : t_read_err

	// A read with one clock too many is a framing error.
	task automatic t_long();
		logic [31:0] rx;
		int d;
		d = n_done;
		i_scd_master.xfer({8'hc0, 7'h2a, 1'b0, 16'h0}, 1'b1, rx);
		`CHK(n_done, d + 1, "long frame end")
		`CHK(got_p, 24'h0ca53c, "long frame answer")
		`CHK(rx, {prev[22:0], resp_crc, 1'b0}, "long wire")
		prev = 24'h0ca53c;
		run({8'hc0, 7'h2a, 1'b0, 16'h0},
			{4'h6, basic_status, 18'h0a53c});
	endtask : t_long

	// Every request code but the reserved error code, then missing data.
	task automatic t_codes();
		logic [31:0] tx;
		logic [23:0] e;
		for (int i = 1; i < 16; i++)
		begin
			tx = {i[3:0], 28'h0};
			if (i == 8 || i == 12)
				tx[23:8] = {7'h2a, 1'b0, i[2] ? 8'h00 : 8'h77};
			casez (i[3:0])
				4'b???1: e = {tx[28], tx[31:29], basic_status, sample_value,
					4'h0, detail_status};
				4'h8: e = {4'h4, basic_status, 2'h0, reg_high_byte, 8'h77};
				4'hc: e = {4'h6, basic_status, 2'h0, 16'ha53c};
				default: e = {22'h030000, detail_status};
			endcase
			run(tx, e);
			`CHK(got_w, i == 8, "write pulse")
		end
		`CHK(write_data, 8'h77, "write data")
		`CHK(write_address, {7'h2a, 1'b0}, "write address")
		sample_valid = 1'b0;
		run({4'h7, 28'h0}, {22'h030000, detail_status});
	endtask : t_codes

	// A reset in mid-run restores the default answer.
	task automatic t_reset();
		nrst = 1'b0;
		#40;
		`CHK(resp_payload, 24'h0c0000, "reset payload")
		nrst = 1'b1;
		#60;
		prev = 24'h0c0000;
		run({4'h1, 28'h0}, {22'h030000, detail_status});
	endtask : t_reset

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// Main sequence.
	initial
	begin
		repeat (10) @(posedge ref_clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		t_read();
		t_read_err();
		t_long();
		t_codes();
		t_reset();
		close_out();
	end
endmodule : scd_decoder_tb_top

bind scd_decoder scd_decoder_properties i_scd_decoder_properties (.ref_clk,
	.nrst, .spi_sclk, .spi_cs_n, .spi_miso, .spi_miso_oe_n, .miso_fault,
	.cmd_crc_ok,
	.reg_high_byte, .reg_low_byte, .cmd_frame, .word_address, .resp_payload,
	.frame_done, .write_req, .write_address);
`default_nettype wire
